/* hw/dwsp_pkg.sv */
// Constants, field layouts and state codes for the dual wiper serial slave port.
// Assumes a 40 MHz system clock; the serial clock comes from the bus master.
package dwsp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int HZ_PER_MHZ = 1_000_000;
	localparam int NV_WRITE_TIME_US = 20_000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * (CLK_HZ / HZ_PER_MHZ);
	localparam int NV_CNT_W = 24;

	// ----------------------------------------------------------------
	// Wiper values and addresses
	// ----------------------------------------------------------------
	localparam int WIPER_W = 8;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [7:0] WIPER_HIGH_END = 8'hff;
	localparam logic [7:0] WIPER_LOW_END = 8'h00;
	localparam logic [7:0] STORE_DEFAULT = 8'h80;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] ADDR_WIPER0 = 8'h00;
	localparam logic [7:0] ADDR_WIPER1 = 8'h01;
	localparam logic [7:0] ADDR_STEP = 8'h01;

	// ----------------------------------------------------------------
	// Identification byte layout
	// ----------------------------------------------------------------
	// Device-type code: value is arbitrary
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;
	localparam int ID_TYPE_MSB = 7;
	localparam int ID_TYPE_LSB = 4;
	localparam int ID_STRAP_MSB = 3;
	localparam int ID_STRAP_LSB = 1;
	localparam int ID_DIR_BIT = 0;
	localparam logic DIR_READ = 1'b1;
	localparam logic ACK_LEVEL = 1'b0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_STEP = 3'h1;

	// ----------------------------------------------------------------
	// Protocol states
	// ----------------------------------------------------------------
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_ID = 10'h002,
		ST_ID_ACK = 10'h004,
		ST_ADDR = 10'h008,
		ST_ADDR_ACK = 10'h010,
		ST_WDATA = 10'h020,
		ST_WDATA_ACK = 10'h040,
		ST_RDATA = 10'h080,
		ST_RACK = 10'h100,
		ST_SKIP = 10'h200
	} dwsp_state_e;

endpackage

/* hw/dwsp_top.sv */
// Two-wire slave port feeding two wiper-position registers of a dual pot.
// Assumes an external pull-up on the data wire and a master-driven serial clock.
//
// Overview of operation
// - Code 255 selects high end, 0 low
// - Tap comes only from wiper register
// - Incoming bits captured on clock rising edge
// - Outgoing data changes only after falling edges
// - Data pin only pulled low or released
// - Straps give low three address bits
// - Respond only when strap address matches
// - Write-ending stop starts timed nonvolatile write
// - Id byte: type, straps, direction bit
// - Acks for id, address, write data
// - Start and stop frame every transfer
// - Preset 80h, then reload from store
`timescale 1ns/1ps

module dwsp_top
	import dwsp_pkg::*;
#(
	parameter int NV_CYCLES = dwsp_pkg::NV_WRITE_CYCLES,
	parameter logic [3:0] DEV_TYPE = dwsp_pkg::DEV_TYPE_DEFAULT
)
(
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic ADDR_STRAP_BIT2_I,
	input wire logic ADDR_STRAP_BIT1_I,
	input wire logic ADDR_STRAP_BIT0_I,
	output logic [dwsp_pkg::WIPER_W-1:0] WIPER0_TAP_O,
	output logic [dwsp_pkg::WIPER_W-1:0] WIPER1_TAP_O,
	output logic NV_BUSY_O
);

	localparam logic [NV_CNT_W-1:0] NV_LAST = NV_CNT_W'(NV_CYCLES - 1);

	logic rst_q;
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic [2:0] strap_s1_q, strap_s2_q;
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic link_bit_q, link_tgl_q;
	dwsp_state_e state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] shift_q, tx_q, tx_d, ptr_q, ptr_d;
	logic drive_q, drive_d, dir_q, wrote_q, recall_q;
	logic [7:0] wiper_position_reg [2];
	logic [7:0] initial_wiper_store [2];
	logic nv_busy_q;
	logic [NV_CNT_W-1:0] nv_cnt_q;
	logic wr_en;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == ADDR_WIPER0) || (a == ADDR_WIPER1);
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] w0,
		input logic [7:0] w1);
		rd_byte = !addr_ok(a) ? UNMAPPED_READ : ((a == ADDR_WIPER1) ? w1 : w0);
	endfunction

	// ----------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------
	// rising-edge bit capture
	always_ff @(posedge SCL_I or posedge rst_q)
	begin
		if (rst_q)
		begin
			link_bit_q <= 1'b0;
			link_tgl_q <= 1'b0;
		end
		else
		begin
			link_bit_q <= SDA_I;
			link_tgl_q <= ~link_tgl_q;
		end
	end

	// drive after falling edge
	// drive_q only changes while the clock is high, after a rising edge or at a start or stop, so it is settled here
	always_ff @(negedge SCL_I or posedge rst_q)
	begin
		if (rst_q)
			SDA_OE_O <= 1'b0;
		else
			SDA_OE_O <= drive_q;
	end

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I)
	begin
		rst_q <= ~RESET_N_I;
		{scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, SCL_I};
		{sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, SDA_I};
		{tgl_s3_q, tgl_s2_q, tgl_s1_q} <= {tgl_s2_q, tgl_s1_q, link_tgl_q};
		strap_s1_q <= {ADDR_STRAP_BIT2_I, ADDR_STRAP_BIT1_I, ADDR_STRAP_BIT0_I};
		strap_s2_q <= strap_s1_q;
	end

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// start and stop detection
	wire start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	wire stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
	wire rise_evt = tgl_s2_q ^ tgl_s3_q;
	wire byte_done = rise_evt && (cnt_q == BIT_LAST);
	wire [7:0] rx_byte = {shift_q[6:0], link_bit_q};
	wire id_match = (rx_byte[ID_TYPE_MSB:ID_TYPE_LSB] == DEV_TYPE)
		&& (rx_byte[ID_STRAP_MSB:ID_STRAP_LSB] == strap_s2_q);
	wire [7:0] rd_now = rd_byte(ptr_q, wiper_position_reg[0], wiper_position_reg[1]);
	wire [7:0] ptr_next = ptr_q + ADDR_STEP;
	wire [7:0] rd_next = rd_byte(ptr_next, wiper_position_reg[0], wiper_position_reg[1]);
	wire bit_state = (state_q == ST_ID) || (state_q == ST_ADDR) || (state_q == ST_WDATA)
		|| (state_q == ST_RDATA);

	// ----------------------------------------------------------------
	// Protocol state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		drive_d = drive_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		wr_en = 1'b0;
		cnt_d = (bit_state && rise_evt) ? cnt_q + BIT_STEP : cnt_q;
		if (start_det)
		begin
			state_d = ST_ID;
			drive_d = 1'b0;
			cnt_d = BIT_FIRST;
		end
		else if (stop_det)
		begin
			state_d = ST_IDLE;
			drive_d = 1'b0;
		end
		else if (rise_evt)
		begin
			case (state_q)
				ST_ID:
					if (byte_done)
					begin
						state_d = id_match ? ST_ID_ACK : ST_SKIP;
						drive_d = id_match;
					end
				ST_ID_ACK:
					if (dir_q == DIR_READ)
					begin
						state_d = ST_RDATA;
						tx_d = rd_now;
						drive_d = ~rd_now[7];
					end
					else
					begin
						state_d = ST_ADDR;
						drive_d = 1'b0;
					end
				ST_ADDR:
					if (byte_done)
					begin
						state_d = ST_ADDR_ACK;
						ptr_d = rx_byte;
						drive_d = 1'b1;
					end
				ST_ADDR_ACK, ST_WDATA_ACK:
				begin
					state_d = ST_WDATA;
					drive_d = 1'b0;
				end
				ST_WDATA:
					if (byte_done)
					begin
						state_d = ST_WDATA_ACK;
						wr_en = addr_ok(ptr_q) && !nv_busy_q;
						ptr_d = ptr_next;
						drive_d = 1'b1;
					end
				ST_RDATA:
				begin
					tx_d = {tx_q[6:0], 1'b0};
					drive_d = byte_done ? 1'b0 : ~tx_q[6];
					if (byte_done)
						state_d = ST_RACK;
				end
				ST_RACK:
					if (link_bit_q == ACK_LEVEL)
					begin
						state_d = ST_RDATA;
						ptr_d = ptr_next;
						tx_d = rd_next;
						drive_d = ~rd_next[7];
					end
					else
						state_d = ST_SKIP;
				ST_IDLE, ST_SKIP:
					drive_d = 1'b0;
				default:
				begin
					state_d = ST_IDLE;
					drive_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (rst_q)
		begin
			state_q <= ST_IDLE;
			cnt_q <= BIT_FIRST;
			drive_q <= 1'b0;
			tx_q <= UNMAPPED_READ;
			ptr_q <= ADDR_WIPER0;
			shift_q <= UNMAPPED_READ;
			dir_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			drive_q <= drive_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			if (rise_evt)
				shift_q <= rx_byte;
			if (byte_done && state_q == ST_ID)
				dir_q <= link_bit_q;
		end
	end

	// ----------------------------------------------------------------
	// Wipers and nonvolatile store
	// ----------------------------------------------------------------
	wire nv_start = stop_det && wrote_q && !nv_busy_q;
	wire nv_done = nv_busy_q && (nv_cnt_q == NV_LAST);

	always_ff @(posedge MCLK_I)
	begin
		if (rst_q)
		begin
			wiper_position_reg[0] <= WIPER_RESET;
			wiper_position_reg[1] <= WIPER_RESET;
			initial_wiper_store[0] <= STORE_DEFAULT;
			initial_wiper_store[1] <= STORE_DEFAULT;
			recall_q <= 1'b1;
			wrote_q <= 1'b0;
			nv_busy_q <= 1'b0;
			nv_cnt_q <= '0;
		end
		else
		begin
			recall_q <= 1'b0;
			if (recall_q)
			begin
				wiper_position_reg[0] <= initial_wiper_store[0];
				wiper_position_reg[1] <= initial_wiper_store[1];
			end
			else if (wr_en)
				wiper_position_reg[ptr_q[0]] <= rx_byte;
			if (start_det || nv_start)
				wrote_q <= 1'b0;
			else if (wr_en)
				wrote_q <= 1'b1;
			if (nv_start)
				nv_busy_q <= 1'b1;
			else if (nv_done)
				nv_busy_q <= 1'b0;
			nv_cnt_q <= nv_busy_q ? nv_cnt_q + NV_CNT_W'(1) : '0;
			if (nv_done)
			begin
				initial_wiper_store[0] <= wiper_position_reg[0];
				initial_wiper_store[1] <= wiper_position_reg[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// register code is the tap
	always_ff @(posedge MCLK_I)
	begin
		if (rst_q)
		begin
			WIPER0_TAP_O <= WIPER_RESET;
			WIPER1_TAP_O <= WIPER_RESET;
			NV_BUSY_O <= 1'b0;
			SDA_O <= 1'b0;
		end
		else
		begin
			WIPER0_TAP_O <= wiper_position_reg[0];
			WIPER1_TAP_O <= wiper_position_reg[1];
			NV_BUSY_O <= nv_busy_q;
			SDA_O <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (rst_q);

	sequence s_nv_run;
		nv_busy_q [*8];
	endsequence

	property p_preset;
		@(posedge MCLK_I) disable iff (1'b0) rst_q ##1 rst_q |-> wiper_position_reg[0] == WIPER_RESET;
	endproperty
	a_preset: assert property (p_preset) else $error("wiper not preset");

	property p_recall;
		recall_q |=> wiper_position_reg[1] == $past(initial_wiper_store[1]);
	endproperty
	a_recall: assert property (p_recall) else $error("store not recalled");

	property p_tap;
		##1 WIPER0_TAP_O == $past(wiper_position_reg[0]) && WIPER1_TAP_O == $past(wiper_position_reg[1]);
	endproperty
	a_tap: assert property (p_tap) else $error("tap not from wiper register");

	property p_low_only;
		SDA_O == 1'b0;
	endproperty
	a_low_only: assert property (p_low_only) else $error("data pin driven high");

	property p_drive_edge;
		$changed(SDA_OE_O) |-> !SCL_I;
	endproperty
	a_drive_edge: assert property (p_drive_edge) else $error("data pin moved with clock high");

	property p_skip_release;
		state_q == ST_SKIP |-> !drive_q;
	endproperty
	a_skip_release: assert property (p_skip_release) else $error("driving after mismatch");

	property p_id_ack;
		byte_done && state_q == ST_ID && !start_det && !stop_det |=>
			drive_q == $past(id_match) && (state_q == ST_ID_ACK) == $past(id_match);
	endproperty
	a_id_ack: assert property (p_id_ack) else $error("id byte answered wrongly");

	property p_nv_start;
		nv_start |=> s_nv_run;
	endproperty
	a_nv_start: assert property (p_nv_start) else $error("nonvolatile write not run");

	property p_capture;
		rise_evt |=> shift_q[0] == $past(link_bit_q);
	endproperty
	a_capture: assert property (p_capture) else $error("bit not captured");

	property p_start;
		start_det |=> state_q == ST_ID && cnt_q == BIT_FIRST && !drive_q;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

endmodule

/* dv/dwsp_master.sv */
// Behavioural two-wire bus master for the serial port.
// Assumes the bench resolves the data wire from both pull-down enables.
`timescale 1ns/1ps
module dwsp_master
(
	output logic scl_o,
	output logic pull_o,
	input wire logic sda_i
);
	localparam int HALF = 240;
	initial
	begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic start();
		#(HALF / 2);
		pull_o = 1'b0;
		#(HALF / 2);
		scl_o = 1'b1;
		#HALF;
		pull_o = 1'b1;
		#HALF;
		scl_o = 1'b0;
	endtask
	task automatic stop();
		#(HALF / 2);
		pull_o = 1'b1;
		#(HALF / 2);
		scl_o = 1'b1;
		#HALF;
		pull_o = 1'b0;
		#HALF;
	endtask
	task automatic bit_io(input logic b, output logic s);
		#(HALF / 2);
		pull_o = !b;
		#(HALF / 2);
		scl_o = 1'b1;
		#(HALF / 2);
		s = sda_i;
		#(HALF / 2);
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(ack_in, ack);
	endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the dual wiper serial slave port.
// Assumes the master model only runs the serial clock inside frames.
`timescale 1ns/1ps
module tb;
	import dwsp_pkg::*;
	localparam int NVC = 2000;
	localparam logic [3:0] DT = DEV_TYPE_DEFAULT;
	typedef struct packed {
		logic [2:0] pins;
		logic [7:0] id;
		logic [7:0] a;
		logic [7:0] d;
		logic [2:0] ak;
		logic [7:0] t0;
		logic [7:0] t1;
	} dwsp_row_s;
	localparam dwsp_row_s ROWS [5] = '{
		'{3'h5, {DT, 3'h5, 1'b0}, 8'h00, 8'hff, 3'h0, 8'hff, 8'h80},
		'{3'h5, {DT, 3'h5, 1'b0}, 8'h01, 8'h00, 3'h0, 8'hff, 8'h00},
		'{3'h5, {DT, 3'h2, 1'b0}, 8'h00, 8'h11, 3'h7, 8'hff, 8'h00},
		'{3'h2, {~DT, 3'h2, 1'b0}, 8'h00, 8'h11, 3'h7, 8'hff, 8'h00},
		'{3'h2, {DT, 3'h2, 1'b0}, 8'h00, 8'h5a, 3'h0, 8'h5a, 8'h00}};
	logic MCLK_I;
	logic RESET_N_I;
	logic [2:0] strap;
	logic scl;
	logic pull;
	logic sda;
	logic SDA_O;
	logic SDA_OE_O;
	logic [7:0] tap0;
	logic [7:0] tap1;
	logic nv_busy;
	int n_fail = 0;
	int num_checks = 0;
	assign sda = !(pull || (SDA_OE_O === 1'b1 && SDA_O === 1'b0));
	dwsp_top #(.NV_CYCLES(NVC), .DEV_TYPE(DT)) dut (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
		.SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
		.ADDR_STRAP_BIT2_I(strap[2]), .ADDR_STRAP_BIT1_I(strap[1]),
		.ADDR_STRAP_BIT0_I(strap[0]), .WIPER0_TAP_O(tap0), .WIPER1_TAP_O(tap1),
		.NV_BUSY_O(nv_busy));
	dwsp_master m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
	initial
	begin
		MCLK_I = 1'b0;
		forever #12.5 MCLK_I = ~MCLK_I;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic rst_chk();
		@(negedge MCLK_I);
		RESET_N_I = 1'b0;
		repeat (20) @(negedge MCLK_I);
		chk("tap0 rst", WIPER_RESET, tap0);
		chk("tap1 rst", WIPER_RESET, tap1);
		RESET_N_I = 1'b1;
		repeat (10) @(negedge MCLK_I);
		chk("tap0 load", STORE_DEFAULT, tap0);
		chk("tap1 load", STORE_DEFAULT, tap1);
		$display("reset test done");
	endtask
	task automatic wr(input logic [7:0] id, input logic [7:0] a, input logic [7:0] d,
		output logic [2:0] ak);
		logic [7:0] q;
		m.start();
		m.xfer(id, 1'b1, q, ak[2]);
		m.xfer(a, 1'b1, q, ak[1]);
		m.xfer(d, 1'b1, q, ak[0]);
		m.stop();
	endtask
	task automatic wait_nv();
		int i;
		i = 0;
		while (nv_busy !== 1'b0 && i < 4 * NVC)
		begin
			@(posedge MCLK_I);
			i++;
		end
		@(negedge MCLK_I);
	endtask
	always @(posedge MCLK_I)
		if (SDA_OE_O === 1'b1)
			chk("sda level", 8'h00, {7'h00, SDA_O});
	initial
	begin
		#2_000_000;
		n_fail++;
		$display("[ERR] watchdog exp done got hang");
		test_done();
	end
	initial
	begin
		logic [2:0] ak;
		logic [7:0] q;
		logic k;
		strap = 3'h5;
		RESET_N_I = 1'b0;
		rst_chk();
		for (int i = 0; i < 5; i++)
		begin
			strap = ROWS[i].pins;
			repeat (30) @(negedge MCLK_I);
			wr(ROWS[i].id, ROWS[i].a, ROWS[i].d, ak);
			chk("acks", {5'h00, ROWS[i].ak}, {5'h00, ak});
			repeat (20) @(negedge MCLK_I);
			wait_nv();
			chk("busy end", 8'h00, {7'h00, nv_busy});
			chk("tap0", ROWS[i].t0, tap0);
			chk("tap1", ROWS[i].t1, tap1);
			$display("row %0d done", i);
		end
		m.start();
		m.xfer({DT, 3'h2, 1'b0}, 1'b1, q, k);
		m.xfer(ADDR_WIPER0, 1'b1, q, k);
		m.xfer(8'h3c, 1'b1, q, k);
		m.xfer(8'hc3, 1'b1, q, k);
		chk("ack d2", {7'h00, ACK_LEVEL}, {7'h00, k});
		m.stop();
		repeat (20) @(negedge MCLK_I);
		chk("busy", 8'h01, {7'h00, nv_busy});
		wr({DT, 3'h2, 1'b0}, ADDR_WIPER0, 8'h77, ak);
		chk("tap0 busy", 8'h3c, tap0);
		chk("tap1 incr", 8'hc3, tap1);
		wait_nv();
		m.start();
		m.xfer({DT, 3'h2, 1'b0}, 1'b1, q, k);
		m.xfer(ADDR_WIPER0, 1'b1, q, k);
		m.start();
		m.xfer({DT, 3'h2, DIR_READ}, 1'b1, q, k);
		m.xfer(8'hff, 1'b0, q, k);
		chk("rd0", 8'h3c, q);
		m.xfer(8'hff, 1'b1, q, k);
		chk("rd1", 8'hc3, q);
		m.stop();
		$display("burst and read test done");
		rst_chk();
		test_done();
	end
endmodule
